/* File: rtl/ccu_pkg.sv */
package ccu_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_CAPSRC = 4'h1;
    localparam logic [3:0] OFS_VAL_LO = 4'h2;
    localparam logic [3:0] OFS_VAL_HI = 4'h3;
    localparam logic [3:0] OFS_TMRSEL = 4'h4;
    localparam logic [3:0] OFS_FLAG = 4'h5;
    localparam logic [3:0] OFS_IRQEN = 4'h6;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_EN_BIT = 7;
    localparam int unsigned CTRL_CONV_BIT = 6;
    localparam int unsigned FLAG_BIT = 0;
    localparam int unsigned IRQEN_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] CAPSRC_RST = 4'h0;
    localparam logic [7:0] VAL_RST = 8'h00;
    localparam logic [1:0] TMRSEL_RST = 2'h1;
    localparam logic [3:0] PRE_RST = 4'h0;

    // ------------------------------------------------------------
    // Timer selection codes
    // ------------------------------------------------------------
    localparam logic [1:0] TSEL_PRI = 2'h1;
    localparam logic [1:0] TSEL_ALT = 2'h2;

    // ------------------------------------------------------------
    // Prescaler terminal counts
    // ------------------------------------------------------------
    localparam logic [1:0] PRE_4TH_LAST = 2'h3;
    localparam logic [3:0] PRE_16TH_LAST = 4'hF;

    // ------------------------------------------------------------
    // Modes and capture sources
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_OFF = 4'h0,
        MODE_CMP_TOGGLE = 4'h2,
        MODE_CAP_FALL = 4'h4,
        MODE_CAP_RISE = 4'h5,
        MODE_CAP_4TH = 4'h6,
        MODE_CAP_16TH = 4'h7,
        MODE_CMP_SET = 4'h8,
        MODE_CMP_CLR = 4'h9,
        MODE_CMP_SW = 4'hA,
        MODE_CMP_TRIG = 4'hB
    } ccu_mode_t;

    localparam logic [3:0] SRC_PIN = 4'h0;
    localparam logic [3:0] SRC_CMP1 = 4'h1;
    localparam logic [3:0] SRC_CMP2 = 4'h2;
    localparam logic [3:0] SRC_NCO = 4'h3;
    localparam logic [3:0] SRC_IOC = 4'h4;
    localparam logic [3:0] SRC_LC1 = 4'h5;
    localparam logic [3:0] SRC_LC2 = 4'h6;
    localparam logic [3:0] SRC_LC3 = 4'h7;
    localparam logic [3:0] SRC_LC4 = 4'h8;

    // ------------------------------------------------------------
    // Mode decoding
    // ------------------------------------------------------------
    function automatic logic is_capture(input logic [3:0] mode);
        return (mode >= 4'h4) && (mode <= 4'h7);
    endfunction

    function automatic logic is_compare(input logic [3:0] mode);
        return (mode == 4'h2) || ((mode >= 4'h8) && (mode <= 4'hB));
    endfunction

endpackage

/* File: rtl/ccu_capq.sv */
`timescale 1ns/1ps
module ccu_capq (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic src_i,
    input wire logic clear_i,
    input wire logic [3:0] mode_i,
    // Event
    output logic event_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [3:0] pre_cnt;
    } ccu_capq_st_t;

    ccu_capq_st_t st_ff;
    ccu_capq_st_t nxt_st;
    logic rise;
    logic fall;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync1 = src_i;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.prev = st_ff.sync2;
        rise = st_ff.sync2 & ~st_ff.prev;
        fall = ~st_ff.sync2 & st_ff.prev;
        event_o = 1'b0;
        unique case (mode_i)
            ccu_pkg::MODE_CAP_FALL: event_o = fall;
            ccu_pkg::MODE_CAP_RISE: event_o = rise;
            ccu_pkg::MODE_CAP_4TH:
                event_o = rise && (st_ff.pre_cnt[1:0] ==
                                   ccu_pkg::PRE_4TH_LAST);
            ccu_pkg::MODE_CAP_16TH:
                event_o = rise && (st_ff.pre_cnt ==
                                   ccu_pkg::PRE_16TH_LAST);
            default: event_o = 1'b0;
        endcase
        if (rise) begin
            nxt_st.pre_cnt = st_ff.pre_cnt + 4'h1;
        end
        if (clear_i) begin
            nxt_st.pre_cnt = ccu_pkg::PRE_RST;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence src_rise_s;
        !src_i ##1 src_i [*3];
    endsequence

    pre_clear_a: assert property (clear_i |=> st_ff.pre_cnt == 4'h0)
        else $error("prescaler not cleared");
    rise_event_a: assert property (
        (mode_i == ccu_pkg::MODE_CAP_RISE && !st_ff.prev && !st_ff.sync2
         && !st_ff.sync1) ##0 src_rise_s and
        (mode_i == ccu_pkg::MODE_CAP_RISE) [*4] |-> event_o)
        else $error("rising edge not seen after two stages");
    single_event_a: assert property (event_o |=> !event_o)
        else $error("one edge counted twice");

endmodule

/* File: rtl/ccu_cmp.sv */
`timescale 1ns/1ps
module ccu_cmp (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Operands
    input wire logic enable_i,
    input wire logic [15:0] value_i,
    input wire logic [15:0] count_i,
    // Match
    output logic match_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic eq_prev;
    } ccu_cmp_st_t;

    ccu_cmp_st_t st_ff;
    ccu_cmp_st_t nxt_st;
    logic eq;

    always_comb begin
        eq = enable_i && (value_i == count_i);
        nxt_st.eq_prev = eq;
        match_o = eq && !st_ff.eq_prev;
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    match_once_a: assert property (
        match_o |=> !match_o)
        else $error("match fired twice on one equality");
    match_cause_a: assert property (
        match_o |-> enable_i && value_i == count_i)
        else $error("match without equal count");

endmodule

/* File: rtl/ccu_unit.sv */
`timescale 1ns/1ps
// Overview of operation
// - The timer select register picks which 16-bit time base drives this unit.
// - A capture event copies the full 16-bit timer count into the value pair.
// - Mode picks falling, rising, every fourth or every sixteenth rising edge.
// - Each capture sets the event flag; only software clears it.
// - A later capture overwrites the earlier value even if unread.
// - With the pin driven as output, writes to its port latch can capture.
// - A 4-bit select chooses among nine capture sources.
// - Prescaler clears when unit off, not capturing, or at reset.
// - Switching prescale modes keeps the prescaler count; software clears control.
// - Sleep halts capture unless the timer is externally clocked.
// - Compare matches value pair with timer, then toggles, sets, clears or signals.
// - Each compare match outside sleep with an internal timer clock sets the flag and may start a conversion.
// - Selected as trigger source, the match also fires a conversion trigger.
// - In sleep with an external timer clock, a match sets the flag and wakes the device when enabled.
// - A match in MODE_CMP_TRIG clears the timer without its overflow event.
// - A software timer write in the same cycle wins over that clear.
module ccu_unit (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Time bases
    input wire logic [15:0] timer_count_i,
    input wire logic [15:0] alt_timer_count_i,
    input wire logic timer_write_i,
    output logic timer_clear_o,
    // Capture sources
    input wire logic pin_in_i,
    input wire logic port_latch_i,
    input wire logic pin_direction_bit_i,
    input wire logic comparator_one_out_i,
    input wire logic comparator_two_out_i,
    input wire logic numeric_osc_out_i,
    input wire logic pin_change_interrupt_i,
    input wire logic [3:0] logic_cell_out_i,
    // Power state
    input wire logic sleep_i,
    input wire logic timer_ext_clk_i,
    // Results
    output logic cmp_out_o,
    output logic conv_trig_o,
    output logic event_flag_o,
    output logic wake_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] unit_control_reg;
        logic [3:0] capture_source_reg;
        logic [7:0] value_high_byte;
        logic [7:0] value_low_byte;
        logic [1:0] timer_select_reg;
        logic event_flag;
        logic event_irq_enable;
        logic cmp_out;
        logic conv_trig;
        logic tmr_clear;
        logic [7:0] rdata;
    } ccu_unit_st_t;

    ccu_unit_st_t st_ff;
    ccu_unit_st_t nxt_st;

    logic [3:0] mode;
    logic enabled;
    logic active;
    logic cap_mode;
    logic cmp_mode;
    logic pin_src;
    logic cap_src;
    logic cap_ev;
    logic match;
    logic take_match;
    logic fire_trig;
    logic set_flag;
    logic [15:0] time_base;
    logic [15:0] value_pair;
    logic [7:0] rd_mux;

    // ------------------------------------------------------------
    // Source and time base selection
    // ------------------------------------------------------------
    always_comb begin
        mode = st_ff.unit_control_reg[3:0];
        enabled = st_ff.unit_control_reg[ccu_pkg::CTRL_EN_BIT];
        active = enabled && (!sleep_i || timer_ext_clk_i);
        cap_mode = ccu_pkg::is_capture(mode);
        cmp_mode = ccu_pkg::is_compare(mode);
        pin_src = pin_direction_bit_i ? pin_in_i : port_latch_i;
        time_base = (st_ff.timer_select_reg == ccu_pkg::TSEL_ALT) ?
                    alt_timer_count_i : timer_count_i;
        value_pair = {st_ff.value_high_byte, st_ff.value_low_byte};
        unique case (st_ff.capture_source_reg)
            ccu_pkg::SRC_PIN: cap_src = pin_src;
            ccu_pkg::SRC_CMP1: cap_src = comparator_one_out_i;
            ccu_pkg::SRC_CMP2: cap_src = comparator_two_out_i;
            ccu_pkg::SRC_NCO: cap_src = numeric_osc_out_i;
            ccu_pkg::SRC_IOC: cap_src = pin_change_interrupt_i;
            ccu_pkg::SRC_LC1: cap_src = logic_cell_out_i[0];
            ccu_pkg::SRC_LC2: cap_src = logic_cell_out_i[1];
            ccu_pkg::SRC_LC3: cap_src = logic_cell_out_i[2];
            ccu_pkg::SRC_LC4: cap_src = logic_cell_out_i[3];
            default: cap_src = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Capture qualifier and comparator
    // ------------------------------------------------------------
    ccu_capq u_capq (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .src_i(cap_src),
        .clear_i(!enabled || !cap_mode),
        .mode_i(mode),
        .event_o(cap_ev)
    );

    ccu_cmp u_cmp (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .enable_i(enabled && cmp_mode),
        .value_i(value_pair),
        .count_i(time_base),
        .match_o(match)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        take_match = match && active && cmp_mode;
        fire_trig = take_match && ((mode == ccu_pkg::MODE_CMP_TRIG) ||
                    st_ff.unit_control_reg[ccu_pkg::CTRL_CONV_BIT]);
        set_flag = (cap_ev && active && cap_mode) || take_match;

        // Register writes
        if (wr_i) begin
            unique case (addr_i)
                ccu_pkg::OFS_CTRL: nxt_st.unit_control_reg = wdata_i;
                ccu_pkg::OFS_CAPSRC: nxt_st.capture_source_reg = wdata_i[3:0];
                ccu_pkg::OFS_VAL_LO: nxt_st.value_low_byte = wdata_i;
                ccu_pkg::OFS_VAL_HI: nxt_st.value_high_byte = wdata_i;
                ccu_pkg::OFS_TMRSEL: nxt_st.timer_select_reg = wdata_i[1:0];
                ccu_pkg::OFS_FLAG:
                    nxt_st.event_flag = wdata_i[ccu_pkg::FLAG_BIT];
                ccu_pkg::OFS_IRQEN:
                    nxt_st.event_irq_enable = wdata_i[ccu_pkg::IRQEN_BIT];
                default: nxt_st.event_flag = st_ff.event_flag;
            endcase
        end

        // Capture overwrites any unread value
        if (cap_ev && active && cap_mode) begin
            nxt_st.value_high_byte = time_base[15:8];
            nxt_st.value_low_byte = time_base[7:0];
        end

        // Compare output actions
        if (take_match) begin
            unique case (mode)
                ccu_pkg::MODE_CMP_TOGGLE: nxt_st.cmp_out = !st_ff.cmp_out;
                ccu_pkg::MODE_CMP_SET: nxt_st.cmp_out = 1'b1;
                ccu_pkg::MODE_CMP_CLR: nxt_st.cmp_out = 1'b0;
                default: nxt_st.cmp_out = st_ff.cmp_out;
            endcase
        end
        nxt_st.conv_trig = fire_trig;
        nxt_st.tmr_clear = take_match &&
                           (mode == ccu_pkg::MODE_CMP_TRIG);

        // Hardware set wins over a software clear
        if (set_flag) begin
            nxt_st.event_flag = 1'b1;
        end

        // Read data for one cycle
        unique case (addr_i)
            ccu_pkg::OFS_CTRL: rd_mux = st_ff.unit_control_reg;
            ccu_pkg::OFS_CAPSRC: rd_mux = {4'h0, st_ff.capture_source_reg};
            ccu_pkg::OFS_VAL_LO: rd_mux = st_ff.value_low_byte;
            ccu_pkg::OFS_VAL_HI: rd_mux = st_ff.value_high_byte;
            ccu_pkg::OFS_TMRSEL: rd_mux = {6'h00, st_ff.timer_select_reg};
            ccu_pkg::OFS_FLAG: rd_mux = {7'h00, st_ff.event_flag};
            ccu_pkg::OFS_IRQEN: rd_mux = {7'h00, st_ff.event_irq_enable};
            default: rd_mux = 8'h00;
        endcase
        nxt_st.rdata = rd_i ? rd_mux : 8'h00;
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff.unit_control_reg <= ccu_pkg::CTRL_RST;
            st_ff.capture_source_reg <= ccu_pkg::CAPSRC_RST;
            st_ff.value_high_byte <= ccu_pkg::VAL_RST;
            st_ff.value_low_byte <= ccu_pkg::VAL_RST;
            st_ff.timer_select_reg <= ccu_pkg::TMRSEL_RST;
            st_ff.event_flag <= 1'b0;
            st_ff.event_irq_enable <= 1'b0;
            st_ff.cmp_out <= 1'b0;
            st_ff.conv_trig <= 1'b0;
            st_ff.tmr_clear <= 1'b0;
            st_ff.rdata <= 8'h00;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata_o = st_ff.rdata;
    assign cmp_out_o = st_ff.cmp_out;
    assign conv_trig_o = st_ff.conv_trig;
    assign event_flag_o = st_ff.event_flag;
    assign timer_clear_o = st_ff.tmr_clear && !timer_write_i;
    assign wake_o = sleep_i && st_ff.event_flag &&
                    st_ff.event_irq_enable;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence cap_hit_s;
        cap_ev && active && cap_mode;
    endsequence

    sequence trig_match_s;
        take_match && mode == ccu_pkg::MODE_CMP_TRIG;
    endsequence

    sequence wake_match_s;
        take_match && st_ff.event_irq_enable && !wr_i ##1 sleep_i;
    endsequence

    capture_load_a: assert property (cap_hit_s |=>
        value_pair == $past(time_base))
        else $error("captured value differs from timer");
    flag_set_a: assert property (set_flag |=> event_flag_o)
        else $error("event did not set flag");
    flag_hold_a: assert property (
        event_flag_o && !(wr_i && addr_i == ccu_pkg::OFS_FLAG)
        |=> event_flag_o)
        else $error("flag dropped without software clear");
    toggle_out_a: assert property (
        take_match && mode == ccu_pkg::MODE_CMP_TOGGLE
        |=> cmp_out_o != $past(cmp_out_o))
        else $error("toggle match left output unchanged");
    timer_clear_a: assert property (
        trig_match_s ##1 !timer_write_i |-> timer_clear_o && conv_trig_o)
        else $error("trigger match did not clear timer");
    write_wins_a: assert property (
        timer_write_i |-> !timer_clear_o)
        else $error("clear issued against a timer write");
    sleep_hold_a: assert property (
        sleep_i && !timer_ext_clk_i |=> !$changed(value_pair) || $past(wr_i))
        else $error("capture ran in sleep with internal clock");
    read_pulse_a: assert property (
        rd_i && addr_i == ccu_pkg::OFS_CAPSRC
        |=> rdata_o == {4'h0, $past(st_ff.capture_source_reg)} ##1
            (rdata_o == 8'h00 || $past(rd_i)))
        else $error("read data wrong or held");
    conv_pulse_a: assert property (conv_trig_o |=> !conv_trig_o)
        else $error("conversion trigger longer than one cycle");
    set_out_a: assert property (
        take_match && mode == ccu_pkg::MODE_CMP_SET |=> cmp_out_o)
        else $error("set match left output low");
    clr_out_a: assert property (
        take_match && mode == ccu_pkg::MODE_CMP_CLR |=> !cmp_out_o)
        else $error("clear match left output high");
    sw_only_a: assert property (
        take_match && mode == ccu_pkg::MODE_CMP_SW |=> $stable(cmp_out_o))
        else $error("flag-only match moved the output");
    trig_sel_a: assert property (
        take_match && st_ff.unit_control_reg[ccu_pkg::CTRL_CONV_BIT]
        |=> conv_trig_o)
        else $error("selected trigger source gave no trigger");
    clear_cause_a: assert property (
        timer_clear_o |-> $past(take_match) &&
        $past(mode) == ccu_pkg::MODE_CMP_TRIG)
        else $error("timer clear without trigger match");
    off_hold_a: assert property (
        !(enabled && cap_mode) && !wr_i |=> $stable(value_pair))
        else $error("value changed outside capture mode");
    sleep_drop_a: assert property (
        sleep_i && !timer_ext_clk_i |=> $stable(cmp_out_o) && !conv_trig_o)
        else $error("compare acted in sleep with internal clock");
    wake_match_a: assert property (wake_match_s |-> wake_o)
        else $error("enabled match in sleep did not wake");

endmodule

/* File: verif/ccu_src_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Capture source model
// ------------------------------------------------------------
module ccu_src_model (
    // Clock
    input wire logic sys_clk_i,
    // Source lines
    output logic [8:0] src_o
);
    logic [8:0] lvl_ff = 9'h000;
    assign src_o = lvl_ff;
    // Level changes after an edge, then holds six cycles
    task automatic drive(input int idx, input logic lvl);
        @(posedge sys_clk_i);
        lvl_ff[idx] <= lvl;
        repeat (6) @(posedge sys_clk_i);
    endtask
endmodule

/* File: verif/capture_compare_unit_tb_top.sv */
`timescale 1ns/1ps
module capture_compare_unit_tb_top;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic [15:0] tc = 16'h0000;
    logic [15:0] alt = 16'h0000;
    logic run = 1'b0;
    logic twr = 1'b0;
    logic dir = 1'b1;
    logic slp = 1'b0;
    logic ext = 1'b0;
    logic [8:0] src;
    logic tclr, cout, conv, flag, wake;
    int err_count = 0;
    int n_compared = 0;
    int n_conv = 0;
    int n_clr = 0;
    ccu_src_model u_src (.sys_clk_i(sys_clk_i), .src_o(src));
    ccu_unit DUT (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .timer_count_i(tc), .alt_timer_count_i(alt), .timer_write_i(twr),
        .timer_clear_o(tclr), .pin_in_i(dir & src[0]),
        .port_latch_i(~dir & src[0]), .pin_direction_bit_i(dir),
        .comparator_one_out_i(src[1]), .comparator_two_out_i(src[2]),
        .numeric_osc_out_i(src[3]), .pin_change_interrupt_i(src[4]),
        .logic_cell_out_i(src[8:5]), .sleep_i(slp), .timer_ext_clk_i(ext),
        .cmp_out_o(cout), .conv_trig_o(conv), .event_flag_o(flag),
        .wake_o(wake));
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    // Timer runs at 1:1 from the instruction clock
    always @(posedge sys_clk_i) begin
        if (run) tc <= tc + 16'h0001;
    end
    always @(negedge sys_clk_i) begin
        n_conv += int'(conv === 1'b1);
        n_clr += int'(tclr === 1'b1);
    end
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic cap_chk(input logic f, input logic [15:0] v);
        logic [7:0] lo, hi;
        rd(ccu_pkg::OFS_FLAG, lo);
        chk({15'h0000, lo[0]}, {15'h0000, f});
        chk({15'h0000, flag}, {15'h0000, f});
        if (f) begin
            rd(ccu_pkg::OFS_VAL_LO, lo);
            rd(ccu_pkg::OFS_VAL_HI, hi);
            chk({hi, lo}, v);
        end
    endtask
    task automatic arm(input logic [3:0] m, input int s);
        wr(ccu_pkg::OFS_CTRL, 8'h00);
        wr(ccu_pkg::OFS_CAPSRC, 8'(s));
        wr(ccu_pkg::OFS_CTRL, {4'h8, m});
        wr(ccu_pkg::OFS_FLAG, 8'h00);
    endtask
    task automatic rises(input int s, input int n);
        repeat (n) begin
            u_src.drive(s, 1'b1);
            u_src.drive(s, 1'b0);
        end
    endtask
    task automatic sweep(input logic [7:0] ctl, input logic [15:0] v);
        @(posedge sys_clk_i);
        tc <= v - 16'h0006;
        wr(ccu_pkg::OFS_VAL_LO, v[7:0]);
        wr(ccu_pkg::OFS_VAL_HI, v[15:8]);
        wr(ccu_pkg::OFS_CTRL, ctl);
        wr(ccu_pkg::OFS_FLAG, 8'h00);
        n_conv = 0;
        n_clr = 0;
        run <= 1'b1;
        repeat (12) @(posedge sys_clk_i);
        run <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask
    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic [15:0] v, w;
        logic [7:0] ctl [6];
        logic ec [6];
        ctl = '{8'h88, 8'h89, 8'h82, 8'h82, 8'hCA, 8'hCB};
        ec = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        void'($urandom(32'h0C2E));
        repeat (4) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(4'(a), d);
            chk({8'h00, d}, (a == 4) ? 16'h0001 : 16'h0000);
        end
        for (int k = 0; k < 10; k++) begin
            v = 16'($urandom);
            dir <= (k != 9);
            tc <= v;
            arm(ccu_pkg::MODE_CAP_RISE, k % 9);
            u_src.drive(k % 9, 1'b1);
            cap_chk(1'b1, v);
            u_src.drive(k % 9, 1'b0);
        end
        arm(ccu_pkg::MODE_CAP_FALL, 1);
        u_src.drive(1, 1'b1);
        cap_chk(1'b0, v);
        u_src.drive(1, 1'b0);
        w = 16'($urandom);
        tc <= w;
        rises(1, 1);
        cap_chk(1'b1, w);
        alt <= 16'($urandom);
        wr(ccu_pkg::OFS_TMRSEL, {6'h00, ccu_pkg::TSEL_ALT});
        arm(ccu_pkg::MODE_CAP_RISE, 2);
        rises(2, 1);
        cap_chk(1'b1, alt);
        wr(ccu_pkg::OFS_TMRSEL, {6'h00, ccu_pkg::TSEL_PRI});
        for (int p = 0; p < 2; p++) begin
            arm(p ? ccu_pkg::MODE_CAP_16TH : ccu_pkg::MODE_CAP_4TH, 5);
            rises(5, p ? 15 : 3);
            cap_chk(1'b0, v);
            rises(5, 1);
            cap_chk(1'b1, w);
        end
        arm(ccu_pkg::MODE_CAP_4TH, 6);
        rises(6, 2);
        arm(ccu_pkg::MODE_CAP_4TH, 6);
        rises(6, 2);
        cap_chk(1'b0, v);
        rises(6, 2);
        cap_chk(1'b1, w);
        slp <= 1'b1;
        arm(ccu_pkg::MODE_CAP_RISE, 3);
        rises(3, 1);
        cap_chk(1'b0, v);
        ext <= 1'b1;
        rises(3, 1);
        cap_chk(1'b1, w);
        slp <= 1'b0;
        ext <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            v = 16'($urandom);
            sweep(ctl[i], v);
            cap_chk(1'b1, v);
            chk({15'h0000, cout}, {15'h0000, ec[i]});
            chk(16'(n_conv), (i >= 4) ? 16'h0001 : 16'h0000);
            chk(16'(n_clr), (i == 5) ? 16'h0001 : 16'h0000);
        end
        twr <= 1'b1;
        sweep(8'hCB, v);
        chk(16'(n_clr), 16'h0000);
        chk(16'(n_conv), 16'h0001);
        twr <= 1'b0;
        slp <= 1'b1;
        sweep(8'h8A, v);
        cap_chk(1'b0, v);
        chk({15'h0000, wake}, 16'h0000);
        ext <= 1'b1;
        wr(ccu_pkg::OFS_IRQEN, 8'h01);
        sweep(8'h8A, v);
        cap_chk(1'b1, v);
        chk({15'h0000, wake}, 16'h0001);
        complete_run();
    end
endmodule
